// >>> hw/bridge_cfg_pkg.sv
// constants, layouts and types of the stack bus bridge configuration
// assumes one clock domain and a 32-bit apb register port
package bridge_cfg_pkg;

    // ************************************************
    // register indices and byte addresses
    // ************************************************
    localparam logic [11:0] IDX_IO_UPPER = 12'h1d5;
    localparam logic [11:0] IDX_IRQ_LOW = 12'h1de;
    localparam logic [11:0] IDX_IRQ_HIGH = 12'h1df;
    localparam logic [11:0] ADDR_IO_UPPER = 12'(IDX_IO_UPPER * 4);
    localparam logic [11:0] ADDR_IRQ_LOW = 12'(IDX_IRQ_LOW * 4);
    localparam logic [11:0] ADDR_IRQ_HIGH = 12'(IDX_IRQ_HIGH * 4);

    // ************************************************
    // field positions, masks and reset values
    // ************************************************
    localparam int MEM_GATE_BIT = 3;
    localparam int WIDE_IO_BIT = 7;
    localparam logic [7:0] IO_UPPER_MASK = 8'h0f;
    localparam logic [7:0] IRQ_LOW_MASK = 8'hff;
    localparam logic [7:0] IRQ_HIGH_MASK = 8'hfb;
    localparam logic [7:0] IO_UPPER_RESET = 8'h00;
    localparam logic [7:0] IRQ_LOW_RESET = 8'h00;
    localparam logic [7:0] IRQ_HIGH_RESET = 8'h00;

    // ************************************************
    // forwarded i/o ranges and memory windows
    // ************************************************
    localparam logic [15:0] IO8_LO = 16'h03e8;
    localparam logic [15:0] IO8_HI = 16'h03ef;
    localparam logic [15:0] IO9_LO = 16'h03f0;
    localparam logic [15:0] IO9_HI = 16'h03f7;
    localparam logic [15:0] IO10_LO = 16'h03f8;
    localparam logic [15:0] IO10_HI = 16'h03ff;
    localparam logic [15:0] IO11_LO = 16'h0400;
    localparam logic [15:0] IO11_HI = 16'h0aff;
    localparam logic [15:0] HOST_MEM_TAG = 16'hffd0;
    localparam logic [3:0] ISA_MEM_TAG = 4'hd;
    localparam logic [7:0] MISS_DATA = 8'hff;

    // ************************************************
    // types
    // ************************************************
    typedef struct packed {
        logic valid;
        logic mem;
        logic write;
        logic [31:0] addr;
        logic [7:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic valid;
        logic mem;
        logic write;
        logic wide;
        logic [19:0] addr;
        logic [15:0] wdata;
    } isa_cyc_s;

    typedef enum logic {ST_IDLE, ST_BUSY} br_state_e;

endpackage

// >>> hw/irq_forward.sv
// per-line gating of expansion bus interrupt requests
// assumes irq inputs are synchronous to clk_sys
`timescale 1ns/1ns
module irq_forward (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // enable registers
    input wire logic [7:0] en_low,
    input wire logic [7:0] en_high,
    // requests in and out, indexed by irq number
    input wire logic [15:0] irq_in,
    output logic [15:0] irq_out
);

    // ************************************************
    // enable map
    // ************************************************
    logic [15:0] en_map;
    logic [15:0] irq_nxt;
    logic [15:0] irq_r;

    assign en_map = {en_high[1], 2'b00, en_high[0], en_low[7:5], 1'b0,
                     en_low[4:0], 3'b000};

    // ************************************************
    // per-line gate
    // ************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_line
            always_comb begin
                irq_nxt[gi] = irq_in[gi] & en_map[gi];
            end

            a_irq_pass_on: assert property (@(posedge clk_sys)
                disable iff (!reset_n)
                (irq_in[gi] && en_map[gi]) |=> irq_out[gi])
                else $error("enabled irq not forwarded");

            a_irq_block_off: assert property (@(posedge clk_sys)
                disable iff (!reset_n)
                !en_map[gi] |=> !irq_out[gi])
                else $error("disabled irq forwarded");
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_r <= 16'h0000;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign irq_out = irq_r;

endmodule

// >>> hw/stack_bridge_cfg.sv
// configuration registers and cycle forwarding of the lpc to pc/104 bridge
// assumes host and expansion side handshakes are synchronous to clk_sys
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns

// Summary of operation
// - block enable 11 forwards i/o ports 0x400 to 0xaff.
// - block enable 10 forwards i/o ports 0x3f8 to 0x3ff.
// - block enable 9 forwards i/o ports 0x3f0 to 0x3f7.
// - block enable 8 forwards i/o ports 0x3e8 to 0x3ef.
// - upper four block bits and irq high bit 2 do nothing.
// - enabled expansion irq lines are passed to the serial irq side.
// - low irq register holds lines 11,10,9,7..3; high holds 15 and 12.
// - zero blocks an irq line, one forwards it.
// - wide mode joins two i/o byte cycles into one 16-bit cycle; memory cycles stay 8-bit.
// - without wide mode every i/o cycle is 8-bit.
// - memory gate 0 maps host 0xffd00000 window to isa 0xd0000.
// - memory gate 1 maps host 0xffd04000 window to isa 0xd4000.
// - memory gate 2 maps host 0xffd08000 window to isa 0xd8000.
// - memory gate 3 maps host 0xffd0c000 window to isa 0xdc000.
// - irq enable registers stay readable and writable at run time.
// - enabled blocks carry writes out and read data back.
module stack_bridge_cfg (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // apb register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host cycle port
    input wire bridge_cfg_pkg::host_req_s host_req,
    output logic host_ack,
    output logic [7:0] host_rdata,
    output logic host_miss,
    // expansion bus cycle port
    output bridge_cfg_pkg::isa_cyc_s isa_cyc,
    input wire logic isa_done,
    input wire logic [15:0] isa_rdata,
    // interrupts
    input wire logic [15:0] isa_irq,
    output logic [15:0] serirq_req
);

    // ************************************************
    // decode helpers
    // ************************************************
    function automatic logic [3:0] io_block(input logic [15:0] a);
        io_block[0] = (a >= bridge_cfg_pkg::IO8_LO) &&
                      (a <= bridge_cfg_pkg::IO8_HI);
        io_block[1] = (a >= bridge_cfg_pkg::IO9_LO) &&
                      (a <= bridge_cfg_pkg::IO9_HI);
        io_block[2] = (a >= bridge_cfg_pkg::IO10_LO) &&
                      (a <= bridge_cfg_pkg::IO10_HI);
        io_block[3] = (a >= bridge_cfg_pkg::IO11_LO) &&
                      (a <= bridge_cfg_pkg::IO11_HI);
    endfunction

    function automatic logic [2:0] reg_sel(input logic [11:0] a);
        reg_sel[0] = (a == bridge_cfg_pkg::ADDR_IO_UPPER);
        reg_sel[1] = (a == bridge_cfg_pkg::ADDR_IRQ_LOW);
        reg_sel[2] = (a == bridge_cfg_pkg::ADDR_IRQ_HIGH);
    endfunction

    // ************************************************
    // register port
    // ************************************************
    logic [7:0] iob_r, iob_nxt;
    logic [7:0] irq_low_r, irq_low_nxt;
    logic [7:0] irq_high_r, irq_high_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic apb_setup;
    logic apb_write;
    logic [2:0] sel;

    assign apb_setup = psel && !penable;
    assign sel = reg_sel(paddr);
    assign apb_write = psel && penable && pready_r && pwrite;

    always_comb begin
        iob_nxt = iob_r;
        irq_low_nxt = irq_low_r;
        irq_high_nxt = irq_high_r;
        prdata_nxt = 32'h0000_0000;
        pready_nxt = apb_setup;
        pslverr_nxt = apb_setup && (sel == 3'b000);
        if (apb_write) begin
            if (sel[0]) begin
                iob_nxt = pwdata[7:0] & bridge_cfg_pkg::IO_UPPER_MASK;
            end
            if (sel[1]) begin
                irq_low_nxt = pwdata[7:0] & bridge_cfg_pkg::IRQ_LOW_MASK;
            end
            if (sel[2]) begin
                irq_high_nxt = pwdata[7:0] & bridge_cfg_pkg::IRQ_HIGH_MASK;
            end
        end
        if (apb_setup && !pwrite) begin
            if (sel[0]) begin
                prdata_nxt = {24'h00_0000, iob_r};
            end else if (sel[1]) begin
                prdata_nxt = {24'h00_0000, irq_low_r};
            end else if (sel[2]) begin
                prdata_nxt = {24'h00_0000, irq_high_r};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            iob_r <= bridge_cfg_pkg::IO_UPPER_RESET;
            irq_low_r <= bridge_cfg_pkg::IRQ_LOW_RESET;
            irq_high_r <= bridge_cfg_pkg::IRQ_HIGH_RESET;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            iob_r <= iob_nxt;
            irq_low_r <= irq_low_nxt;
            irq_high_r <= irq_high_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ************************************************
    // forwarding decision
    // ************************************************
    logic wide_mode;
    logic [3:0] mem_gates;
    logic [3:0] req_blk;
    logic io_ok, mem_ok, hit, take, pair_ok, cache_hit;
    logic [19:0] req_isa_addr;

    assign wide_mode = irq_high_r[bridge_cfg_pkg::WIDE_IO_BIT];
    assign mem_gates = irq_high_r[bridge_cfg_pkg::MEM_GATE_BIT +: 4];
    assign req_blk = io_block(host_req.addr[15:0]);
    assign io_ok = !host_req.mem && (host_req.addr[31:16] == 16'h0000) &&
                   ((req_blk & iob_r[3:0]) != 4'h0);
    assign mem_ok = host_req.mem &&
                    (host_req.addr[31:16] == bridge_cfg_pkg::HOST_MEM_TAG) &&
                    mem_gates[host_req.addr[15:14]];
    assign req_isa_addr = host_req.mem ?
                          {bridge_cfg_pkg::ISA_MEM_TAG, host_req.addr[15:0]} :
                          {4'h0, host_req.addr[15:0]};
    assign hit = io_ok || mem_ok;

    // ************************************************
    // cycle state machine
    // ************************************************
    bridge_cfg_pkg::br_state_e st_r, st_nxt;
    bridge_cfg_pkg::isa_cyc_s isa_r, isa_nxt;
    logic ack_r, ack_nxt;
    logic miss_r, miss_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic pend_r, pend_nxt;
    logic [15:0] pend_addr_r, pend_addr_nxt;
    logic [7:0] pend_data_r, pend_data_nxt;
    logic cache_v_r, cache_v_nxt;
    logic [15:0] cache_addr_r, cache_addr_nxt;
    logic [7:0] cache_data_r, cache_data_nxt;
    logic flush_r, flush_nxt;
    logic rd_wide_r, rd_wide_nxt;

    assign take = host_req.valid && !ack_r && (st_r == bridge_cfg_pkg::ST_IDLE);
    assign pair_ok = io_ok && host_req.write && wide_mode &&
                     (host_req.addr[15:0] == pend_addr_r + 16'h0001);
    assign cache_hit = cache_v_r && wide_mode && io_ok && !host_req.write &&
                       (host_req.addr[15:0] == cache_addr_r);

    always_comb begin
        st_nxt = st_r;
        isa_nxt = isa_r;
        ack_nxt = 1'b0;
        miss_nxt = 1'b0;
        rdata_nxt = rdata_r;
        pend_nxt = pend_r;
        pend_addr_nxt = pend_addr_r;
        pend_data_nxt = pend_data_r;
        cache_v_nxt = cache_v_r;
        cache_addr_nxt = cache_addr_r;
        cache_data_nxt = cache_data_r;
        flush_nxt = flush_r;
        rd_wide_nxt = rd_wide_r;
        unique case (st_r)
            bridge_cfg_pkg::ST_IDLE: begin
                if (pend_r && (!wide_mode || (take && !pair_ok))) begin
                    // unpaired low byte goes out alone
                    isa_nxt = '{1'b1, 1'b0, 1'b1, 1'b0,
                                {4'h0, pend_addr_r}, {8'h00, pend_data_r}};
                    pend_nxt = 1'b0;
                    flush_nxt = 1'b1;
                    rd_wide_nxt = 1'b0;
                    st_nxt = bridge_cfg_pkg::ST_BUSY;
                end else if (take && pend_r) begin
                    isa_nxt = '{1'b1, 1'b0, 1'b1, 1'b1, {4'h0, pend_addr_r},
                                {host_req.wdata, pend_data_r}};
                    pend_nxt = 1'b0;
                    flush_nxt = 1'b0;
                    rd_wide_nxt = 1'b0;
                    st_nxt = bridge_cfg_pkg::ST_BUSY;
                end else if (take && cache_hit) begin
                    ack_nxt = 1'b1;
                    rdata_nxt = cache_data_r;
                    cache_v_nxt = 1'b0;
                end else if (take) begin
                    cache_v_nxt = 1'b0;
                    if (!hit) begin
                        ack_nxt = 1'b1;
                        miss_nxt = 1'b1;
                        rdata_nxt = bridge_cfg_pkg::MISS_DATA;
                    end else if (io_ok && wide_mode && !host_req.addr[0] &&
                                 host_req.write) begin
                        pend_nxt = 1'b1;
                        pend_addr_nxt = host_req.addr[15:0];
                        pend_data_nxt = host_req.wdata;
                        ack_nxt = 1'b1;
                    end else begin
                        isa_nxt = '{1'b1, host_req.mem, host_req.write,
                                    io_ok && wide_mode && !host_req.addr[0],
                                    req_isa_addr, {8'h00, host_req.wdata}};
                        rd_wide_nxt = io_ok && wide_mode && !host_req.addr[0];
                        flush_nxt = 1'b0;
                        st_nxt = bridge_cfg_pkg::ST_BUSY;
                    end
                end
            end
            bridge_cfg_pkg::ST_BUSY: begin
                if (isa_done) begin
                    isa_nxt.valid = 1'b0;
                    st_nxt = bridge_cfg_pkg::ST_IDLE;
                    if (!flush_r) begin
                        ack_nxt = 1'b1;
                        rdata_nxt = isa_r.write ? rdata_r : isa_rdata[7:0];
                        if (rd_wide_r && !isa_r.write) begin
                            cache_v_nxt = 1'b1;
                            cache_addr_nxt = isa_r.addr[15:0] + 16'h0001;
                            cache_data_nxt = isa_rdata[15:8];
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= bridge_cfg_pkg::ST_IDLE;
            isa_r <= '0;
            ack_r <= 1'b0;
            miss_r <= 1'b0;
            rdata_r <= 8'h00;
            pend_r <= 1'b0;
            pend_addr_r <= 16'h0000;
            pend_data_r <= 8'h00;
            cache_v_r <= 1'b0;
            cache_addr_r <= 16'h0000;
            cache_data_r <= 8'h00;
            flush_r <= 1'b0;
            rd_wide_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            isa_r <= isa_nxt;
            ack_r <= ack_nxt;
            miss_r <= miss_nxt;
            rdata_r <= rdata_nxt;
            pend_r <= pend_nxt;
            pend_addr_r <= pend_addr_nxt;
            pend_data_r <= pend_data_nxt;
            cache_v_r <= cache_v_nxt;
            cache_addr_r <= cache_addr_nxt;
            cache_data_r <= cache_data_nxt;
            flush_r <= flush_nxt;
            rd_wide_r <= rd_wide_nxt;
        end
    end

    // ************************************************
    // interrupt forwarding
    // ************************************************
    irq_forward u_irq_forward (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .en_low(irq_low_r),
        .en_high(irq_high_r),
        .irq_in(isa_irq),
        .irq_out(serirq_req)
    );

    // ************************************************
    // outputs
    // ************************************************
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign host_ack = ack_r;
    assign host_miss = miss_r;
    assign host_rdata = rdata_r;
    assign isa_cyc = isa_r;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    logic [3:0] isa_blk;
    assign isa_blk = io_block(isa_cyc.addr[15:0]);

    a_block11_gate: assert property ($rose(isa_cyc.valid) && !isa_cyc.mem
        && isa_blk[3] |-> $past(iob_r[3]))
        else $error("block 11 forwarded while disabled");
    a_block10_gate: assert property ($rose(isa_cyc.valid) && !isa_cyc.mem
        && isa_blk[2] |-> $past(iob_r[2]))
        else $error("block 10 forwarded while disabled");
    a_block9_gate: assert property ($rose(isa_cyc.valid) && !isa_cyc.mem
        && isa_blk[1] |-> $past(iob_r[1]))
        else $error("block 9 forwarded while disabled");
    a_block8_gate: assert property ($rose(isa_cyc.valid) && !isa_cyc.mem
        && isa_blk[0] |-> $past(iob_r[0]))
        else $error("block 8 forwarded while disabled");
    a_mem_window_gate: assert property ($rose(isa_cyc.valid) && isa_cyc.mem
        |-> ((($past(mem_gates) >> isa_cyc.addr[15:14]) & 4'h1) == 4'h1)
        && (isa_cyc.addr[19:16] == bridge_cfg_pkg::ISA_MEM_TAG))
        else $error("memory window forwarded while disabled");
    a_rsvd_read_zero: assert property (apb_setup && !pwrite && sel[0]
        ##1 pready |-> (prdata[31:4] == 28'h000_0000))
        else $error("reserved block bits read nonzero");
    a_rsvd_high_zero: assert property (apb_setup && !pwrite && sel[2]
        |=> !prdata[2] && (prdata[31:8] == 24'h00_0000))
        else $error("reserved irq bit read nonzero");
    a_cfg_write_take: assert property (apb_write && sel[1]
        |=> irq_low_r == $past(pwdata[7:0]))
        else $error("irq enable write not stored");
    a_narrow_io_only: assert property (isa_cyc.valid && !isa_cyc.mem &&
        isa_cyc.wide |-> $past(wide_mode) || wide_mode)
        else $error("wide cycle without wide mode");

    sequence s_second_byte;
        take && pend_r && pair_ok;
    endsequence
    sequence s_wide_out;
        isa_cyc.valid && isa_cyc.wide && isa_cyc.write;
    endsequence
    a_wide_pair_out: assert property (s_second_byte |=> s_wide_out and
        (isa_cyc.wdata[7:0] == $past(pend_data_r)))
        else $error("byte pair not joined");
    a_miss_not_driven: assert property (take && !hit && !pend_r
        |=> (host_ack && host_miss && !isa_cyc.valid) ##1 !isa_cyc.valid)
        else $error("unmapped cycle reached expansion bus");
    a_read_data_back: assert property (st_r == bridge_cfg_pkg::ST_BUSY &&
        isa_done && !flush_r && !isa_cyc.write
        |=> host_ack && host_rdata == $past(isa_rdata[7:0]))
        else $error("read data not returned");

endmodule

// >>> verif/isa_model.sv
// expansion card model answering bridge cycles
// assumes isa_cyc is registered on clk_sys
`timescale 1ns/1ns
module isa_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // cycle in, answer out
    input wire bridge_cfg_pkg::isa_cyc_s isa_cyc,
    input wire logic [3:0] slow,
    output logic isa_done,
    output logic [15:0] isa_rdata
);
    logic [3:0] wait_r;
    logic [7:0] lo;
    logic go;
    assign lo = isa_cyc.addr[7:0];
    assign go = isa_cyc.valid && !isa_done;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            isa_done <= 1'b0;
            wait_r <= 4'h0;
            isa_rdata <= 16'h0000;
        end else if (go && wait_r == slow) begin
            isa_done <= 1'b1;
            wait_r <= 4'h0;
            isa_rdata <= {isa_cyc.wide ? ~lo : lo, lo};
        end else begin
            isa_done <= 1'b0;
            wait_r <= go ? wait_r + 4'h1 : 4'h0;
            isa_rdata <= ~isa_rdata;
        end
    end
endmodule

// >>> verif/stack_bridge_cfg_tb_top.sv
// self-checking bench of the bridge configuration block
// assumes the isa_model partner on the expansion side
`timescale 1ns/1ns
module stack_bridge_cfg_tb_top;
    logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    bridge_cfg_pkg::host_req_s host_req;
    bridge_cfg_pkg::isa_cyc_s isa_cyc, last;
    logic host_ack, host_miss, isa_done, err;
    logic [7:0] host_rdata, hd;
    logic [15:0] isa_rdata, isa_irq, serirq_req;
    logic [3:0] slow;
    int errors, compares, ncyc, n0;

    stack_bridge_cfg dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_req(host_req), .host_ack(host_ack),
        .host_rdata(host_rdata), .host_miss(host_miss), .isa_cyc(isa_cyc),
        .isa_done(isa_done), .isa_rdata(isa_rdata), .isa_irq(isa_irq),
        .serirq_req(serirq_req));
    isa_model card (.clk_sys(clk_sys), .reset_n(reset_n),
        .isa_cyc(isa_cyc), .slow(slow), .isa_done(isa_done),
        .isa_rdata(isa_rdata));

    // ************************************************
    // clock, monitor and bus tasks
    // ************************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (isa_cyc.valid === 1'b1 && isa_done === 1'b1) begin
            last = isa_cyc;
            ncyc++;
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic host(input logic m, input logic w, input logic [31:0] a,
                        input logic [7:0] d);
        @(posedge clk_sys);
        host_req <= '{1'b1, m, w, a, d};
        do begin
            @(posedge clk_sys);
        end while (host_ack !== 1'b1);
        hd = host_rdata;
        err = host_miss;
        host_req.valid <= 1'b0;
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_regs();
        logic [11:0] ad [3] = '{12'h754, 12'h778, 12'h77c};
        logic [7:0] m [3] = '{8'h0f, 8'hff, 8'hfb};
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ad[i], 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            apb(1'b1, ad[i], 32'hffff_ffff);
            apb(1'b0, ad[i], 32'h0000_0000);
            chk(rd, {24'h00_0000, m[i]});
            chk(err, 1'b0);
            apb(1'b1, ad[i], 32'h0000_0000);
        end
        apb(1'b0, 12'h758, 32'h0000_0000);
        chk({rd[7:0], 7'h00, err}, 16'h0001);
    endtask
    task automatic t_io();
        logic [15:0] lo [4] = '{16'h03e8, 16'h03f0, 16'h03f8, 16'h0400};
        logic [15:0] hi [4] = '{16'h03ef, 16'h03f7, 16'h03ff, 16'h0aff};
        logic [15:0] a;
        slow <= 4'h3;
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, 12'h754, 32'h0000_00f0 | 32'(1 << g));
            for (int r = 0; r < 8; r++) begin
                a = r[0] ? hi[r/2] : lo[r/2];
                n0 = ncyc;
                host(1'b0, 1'b1, {16'h0000, a}, 8'h3c);
                chk(err, (r / 2) != g);
                chk(ncyc - n0, (r / 2) == g);
                if ((r / 2) == g) begin
                    chk({last.addr, last.wdata[7:0]}, {4'h0, a, 8'h3c});
                end
            end
        end
        host(1'b0, 1'b0, 32'h0000_0a55, 8'h00);
        chk({err, hd}, 9'h055);
        host(1'b0, 1'b1, 32'h0000_0b00, 8'h00);
        chk(err, 1'b1);
    endtask
    task automatic t_mem();
        slow <= 4'h1;
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, 12'h77c, 32'(8 << g));
            host(1'b1, 1'b0, 32'hffd0_3ffe + 32'(g * 16'h4000), 8'h00);
            chk({err, hd, last.mem}, 10'h1fd);
            chk(last.addr, 20'hd_3ffe + 20'(g * 16'h4000));
            host(1'b1, 1'b0, 32'hffd0_0000 + 32'(((g + 1) % 4) * 16'h4000),
                 8'h00);
            chk(err, 1'b1);
        end
    endtask
    task automatic irq(input logic [7:0] l, input logic [7:0] h,
                       input logic [15:0] exp);
        apb(1'b1, 12'h778, {24'h00_0000, l});
        apb(1'b1, 12'h77c, {24'h00_0000, h});
        @(posedge clk_sys);
        isa_irq <= 16'hffff;
        repeat (3) @(posedge clk_sys);
        chk(serirq_req, exp);
        isa_irq <= 16'h0000;
    endtask
    task automatic t_wide();
        slow <= 4'h0;
        apb(1'b1, 12'h754, 32'h0000_0008);
        apb(1'b1, 12'h77c, 32'h0000_0080);
        n0 = ncyc;
        host(1'b0, 1'b1, 32'h0000_0400, 8'h11);
        chk({err, 8'(ncyc - n0)}, 9'h000);
        host(1'b0, 1'b1, 32'h0000_0401, 8'h22);
        chk({last.wide, last.addr, last.wdata}, 37'h10_0400_2211);
        host(1'b0, 1'b0, 32'h0000_0402, 8'h00);
        chk({last.wide, hd}, 9'h102);
        host(1'b0, 1'b0, 32'h0000_0403, 8'h00);
        chk({hd, 8'(ncyc - n0)}, 16'hfd02);
        apb(1'b1, 12'h77c, 32'h0000_0000);
        host(1'b0, 1'b1, 32'h0000_0400, 8'h33);
        chk({last.wide, 8'(ncyc - n0)}, 9'h003);
    endtask
    task automatic final_report();
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        host_req = '0;
        isa_irq = 16'h0000;
        slow = 4'h2;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs();
        t_io();
        t_mem();
        irq(8'ha5, 8'h07, 16'h9a28);
        irq(8'hff, 8'h03, 16'h9ef8);
        irq(8'h00, 8'hfc, 16'h0000);
        t_wide();
        final_report();
    end
    initial begin
        #400000;
        errors++;
        final_report();
    end
endmodule
